// ===== bench/power_budget_vc_capability_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "pbvc_params.svh"
module power_budget_vc_capability_regs_tb_top;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic ce = 1'b1;
   logic upstream = 1'b1;
   logic vc1_present = 1'b0;
   logic [7:0] data_sel = 8'h00;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [31:0] rd;
   logic er;
   int n_fail = 0;
   int checked = 0;

   always #2 clk = ~clk;

   pbvc_regs uut (.CLK(clk), .RSTN(rstn), .CE(ce), .UPSTREAM(upstream),
      .VC1_PRESENT(vc1_present), .DATA_SEL(data_sel), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr));

   task automatic tally_and_finish;
      $display("Comparisons %0d, mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Request held until the edge that samples pready high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         n_fail++;
         tally_and_finish();
      end else begin
         rd = prdata;
         er = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask

   task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input logic eerr);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
      chk({31'h0, er}, {31'h0, eerr});
   endtask

   // Only the two defined indexes carry a budget
   function automatic logic [31:0] exp_data(input logic [7:0] s);
      if (s == 8'h00) return 32'h000b_8004;
      if (s == 8'h01) return 32'h0009_8003;
      return 32'h0;
   endfunction

   task automatic s_budget;
      logic [7:0] idx [4] = '{8'h00, 8'h01, 8'h02, 8'hff};
      upstream <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         data_sel <= idx[i];
         rchk(`PBVC_OFF_PB_DATA, exp_data(idx[i]), 1'b0);
      end
      rchk(`PBVC_OFF_PB_CAP, 32'h0000_0001, 1'b0);
   endtask

   task automatic s_down;
      upstream <= 1'b0;
      data_sel <= 8'h00;
      rchk(`PBVC_OFF_PB_DATA, 32'h0, 1'b1);
      rchk(`PBVC_OFF_PB_CAP, 32'h0, 1'b1);
   endtask

   task automatic s_vc;
      for (int i = 0; i < 4; i++) begin
         upstream <= i[0];
         vc1_present <= i[1];
         rchk(`PBVC_OFF_VC_HDR, {i[0] ? 12'h270 : 12'h520, 20'h1_0002}, 1'b0);
         rchk(`PBVC_OFF_VC_CAP1, 32'h0000_0800, 1'b0);
         rchk(`PBVC_OFF_VC_CAP2, {i[1] ? 8'h04 : 8'h00, 24'h0}, 1'b0);
      end
   endtask

   // All-ones write would expose any writable or reserved bit in every word but the first channel capability word, which is not read back
   task automatic s_write;
      upstream <= 1'b1;
      vc1_present <= 1'b1;
      data_sel <= 8'h01;
      for (int i = 0; i < 5; i++) begin
         apb(1'b1, 12'h140 + 12'(4 * i), 32'hffff_ffff);
         chk(rd, 32'h0);
         chk({31'h0, er}, 32'h0);
      end
      rchk(`PBVC_OFF_PB_DATA, 32'h0009_8003, 1'b0);
      rchk(`PBVC_OFF_PB_CAP, 32'h0000_0001, 1'b0);
      rchk(`PBVC_OFF_VC_HDR, 32'h2701_0002, 1'b0);
      rchk(`PBVC_OFF_VC_CAP2, 32'h0400_0000, 1'b0);
      rchk(12'h154, 32'h0, 1'b1);
   endtask

   // Setup lands in frozen cycles; the answer waits for the enable
   task automatic s_freeze;
      int n;
      n = 0;
      @(posedge clk);
      ce <= 1'b0;
      upstream <= 1'b1;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= 1'b0;
      paddr <= `PBVC_OFF_VC_HDR;
      @(posedge clk);
      penable <= 1'b1;
      repeat (3) begin
         @(posedge clk);
         chk({31'h0, pready}, 32'h0);
      end
      ce <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         n_fail++;
         tally_and_finish();
      end
      chk(prdata, 32'h2701_0002);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   initial begin
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      s_budget();
      s_down();
      s_vc();
      s_write();
      s_freeze();
      tally_and_finish();
   end
endmodule
`default_nettype wire

// ===== rtl/pbvc_params.svh
`ifndef PBVC_PARAMS_SVH
`define PBVC_PARAMS_SVH

// Register byte offsets
`define PBVC_OFF_PB_DATA 12'h140
`define PBVC_OFF_PB_CAP 12'h144
`define PBVC_OFF_VC_HDR 12'h148
`define PBVC_OFF_VC_CAP1 12'h14c
`define PBVC_OFF_VC_CAP2 12'h150

// Power budget data fields
`define PBVC_PWR_IDX0 8'h04
`define PBVC_PWR_IDX1 8'h03
`define PBVC_TYPE_IDX0 3'h7
`define PBVC_TYPE_IDX1 3'h3
`define PBVC_SCALE 2'h0
`define PBVC_PM_D0 2'h0
`define PBVC_SUBSTATE 3'h0
`define PBVC_RAIL 3'h2
`define PBVC_SEL_MAX 8'h00
`define PBVC_SEL_SUST 8'h01
`define PBVC_SYS_ALLOC 1'h1

// Virtual channel header and capabilities
`define PBVC_VC_CAP_ID 16'h0002
`define PBVC_VC_CAP_VER 4'h1
`define PBVC_NEXT_UP 12'h270
`define PBVC_NEXT_DOWN 12'h520
`define PBVC_EXT_VC_CNT 3'h0
`define PBVC_LP_VC_CNT 3'h0
`define PBVC_REF_CLK 2'h0
`define PBVC_ENTRY_SIZE 2'h2
`define PBVC_VC_ARB_CAP 8'h00
`define PBVC_ARB_OFF_NO_VC1 8'h00
`define PBVC_ARB_OFF_VC1 8'h04

`endif

// ===== rtl/pbvc_pkg.sv
`default_nettype none
package pbvc_pkg;

   typedef struct packed {
      logic [10:0] rsvd;
      logic [2:0] rail;
      logic [2:0] cond_type;
      logic [1:0] pm_state;
      logic [2:0] pm_substate;
      logic [1:0] scale;
      logic [7:0] base_power;
   } pbvc_pb_data_t;

   typedef struct packed {
      logic [19:0] rsvd_hi;
      logic [1:0] entry_size;
      logic [1:0] ref_clk;
      logic rsvd7;
      logic [2:0] lp_vc_cnt;
      logic rsvd3;
      logic [2:0] ext_vc_cnt;
   } pbvc_vc_cap1_t;

   typedef struct packed {
      logic [7:0] arb_tbl_off;
      logic [15:0] rsvd;
      logic [7:0] vc_arb_cap;
   } pbvc_vc_cap2_t;

   typedef struct packed {
      logic [11:0] next_off;
      logic [3:0] version;
      logic [15:0] cap_id;
   } pbvc_vc_hdr_t;

   typedef enum logic [1:0] {
      PBVC_IDLE = 2'b01,
      PBVC_ACC = 2'b10
   } pbvc_state_t;

endpackage
`default_nettype wire

// ===== rtl/pbvc_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "pbvc_params.svh"

// Functional notes
// - Base power 04h index 0, 03h index 1
// - Condition type 111b index 0, 011b index 1
// - Data scale reads 00b
// - PM state reports D0
// - PM sub-state fixed at zero
// - Power rail reads 010b index 0 and 1, 000b for any other index
// - System allocated bit reads 1
// - Power budget registers on upstream port only
// - VC header ID 0002h, version 1h
// - Next offset 270h up, 520h down
// - Extended VC count reads 000b
// - Low-priority VC count reads 000b
// - Reference clock field reads 00b
// - Arbitration entry size reads 10b
// - VC arbitration capability reads 00h
// - Arbitration table offset 00h/04h by VC1
module pbvc_regs
   import pbvc_pkg::*;
(
   // Clock and reset
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic CE,
   // Port configuration
   input wire logic UPSTREAM,
   input wire logic VC1_PRESENT,
   input wire logic [7:0] DATA_SEL,
   // APB slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR
);

   logic rst_meta_r;
   logic rst_sync_r;
   pbvc_state_t state_r;
   pbvc_state_t state_nxt;
   logic [31:0] rdata_nxt;
   logic err_nxt;

   // Reset release through two flops
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         rst_meta_r <= 1'b0;
         rst_sync_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_sync_r <= rst_meta_r;
      end
   end

   // Power budget data, driven by the select index
   wire sel_max = (DATA_SEL == `PBVC_SEL_MAX);
   wire sel_sust = (DATA_SEL == `PBVC_SEL_SUST);
   wire sel_known = sel_max | sel_sust;
   pbvc_pb_data_t pb_data;
   assign pb_data.rsvd = '0;
   assign pb_data.base_power = sel_max ? `PBVC_PWR_IDX0 :
                               sel_sust ? `PBVC_PWR_IDX1 : 8'h00;
   assign pb_data.cond_type = sel_max ? `PBVC_TYPE_IDX0 :
                              sel_sust ? `PBVC_TYPE_IDX1 : 3'h0;
   assign pb_data.scale = `PBVC_SCALE;
   assign pb_data.pm_state = `PBVC_PM_D0;
   // Hard constant: not loadable from the configuration memory
   assign pb_data.pm_substate = `PBVC_SUBSTATE;
   // Unknown index reports zero budget throughout
   assign pb_data.rail = sel_known ? `PBVC_RAIL : 3'h0;

   wire [31:0] pb_cap = {31'h0, `PBVC_SYS_ALLOC};

   pbvc_vc_hdr_t vc_hdr;
   assign vc_hdr.cap_id = `PBVC_VC_CAP_ID;
   assign vc_hdr.version = `PBVC_VC_CAP_VER;
   assign vc_hdr.next_off = UPSTREAM ? `PBVC_NEXT_UP : `PBVC_NEXT_DOWN;

   pbvc_vc_cap1_t vc_cap1;
   assign vc_cap1.rsvd_hi = '0;
   assign vc_cap1.entry_size = `PBVC_ENTRY_SIZE;
   assign vc_cap1.ref_clk = `PBVC_REF_CLK;
   assign vc_cap1.rsvd7 = 1'b0;
   assign vc_cap1.lp_vc_cnt = `PBVC_LP_VC_CNT;
   assign vc_cap1.rsvd3 = 1'b0;
   assign vc_cap1.ext_vc_cnt = `PBVC_EXT_VC_CNT;

   pbvc_vc_cap2_t vc_cap2;
   assign vc_cap2.arb_tbl_off = VC1_PRESENT ? `PBVC_ARB_OFF_VC1 :
                                `PBVC_ARB_OFF_NO_VC1;
   assign vc_cap2.rsvd = '0;
   assign vc_cap2.vc_arb_cap = `PBVC_VC_ARB_CAP;

   // Address decode; budget words vanish on a downstream port
   wire hit_pb_data = UPSTREAM && (PADDR == `PBVC_OFF_PB_DATA);
   wire hit_pb_cap = UPSTREAM && (PADDR == `PBVC_OFF_PB_CAP);
   wire hit_vc_hdr = (PADDR == `PBVC_OFF_VC_HDR);
   wire hit_cap1 = (PADDR == `PBVC_OFF_VC_CAP1);
   wire hit_cap2 = (PADDR == `PBVC_OFF_VC_CAP2);
   wire hit_any = hit_pb_data | hit_pb_cap | hit_vc_hdr | hit_cap1 | hit_cap2;

   wire [31:0] rd_mux = hit_pb_data ? pb_data :
                        hit_pb_cap ? pb_cap :
                        hit_vc_hdr ? vc_hdr :
                        hit_cap1 ? vc_cap1 :
                        hit_cap2 ? vc_cap2 : 32'h0;

   // No wait state: answer registered so every output is a flop
   always_comb begin
      state_nxt = state_r;
      rdata_nxt = PRDATA;
      err_nxt = PSLVERR;
      case (state_r)
         PBVC_IDLE: begin
            // Any phase: a setup that fell in a frozen cycle is still served
            if (PSEL) begin
               state_nxt = PBVC_ACC;
               // Writes are accepted and dropped
               rdata_nxt = PWRITE ? 32'h0 : rd_mux;
               err_nxt = !hit_any;
            end
         end
         PBVC_ACC: begin
            state_nxt = PBVC_IDLE;
            rdata_nxt = 32'h0;
            err_nxt = 1'b0;
         end
         default: state_nxt = PBVC_IDLE;
      endcase
   end

   always_ff @(posedge CLK or negedge rst_sync_r) begin
      if (!rst_sync_r) begin
         state_r <= PBVC_IDLE;
         PRDATA <= 32'h0;
         PSLVERR <= 1'b0;
         PREADY <= 1'b0;
      end else if (CE) begin
         state_r <= state_nxt;
         PRDATA <= rdata_nxt;
         PSLVERR <= err_nxt;
         PREADY <= (state_nxt == PBVC_ACC);
      end
   end

   // Checks
   property p_rd(logic hit, logic [31:0] val);
      @(posedge CLK) disable iff (!rst_sync_r)
      (CE && state_r == PBVC_IDLE && PSEL && !PENABLE && !PWRITE && hit)
      |=> (PREADY && PRDATA == val);
   endproperty

   pb_data_max_a: assert property (p_rd(hit_pb_data && sel_max, 32'h000b_8004))
      else $error("budget data wrong for index 0");
   pb_data_sust_a: assert property (p_rd(hit_pb_data && sel_sust, 32'h0009_8003))
      else $error("budget data wrong for index 1");
   pb_data_other_a: assert property (p_rd(hit_pb_data && !sel_known, 32'h0))
      else $error("unknown index not zero");
   pb_cap_read_a: assert property (p_rd(hit_pb_cap, 32'h1))
      else $error("system allocated bit wrong");
   vc_hdr_up_a: assert property (p_rd(hit_vc_hdr && UPSTREAM, 32'h2701_0002))
      else $error("upstream vc header wrong");
   vc_hdr_down_a: assert property (p_rd(hit_vc_hdr && !UPSTREAM, 32'h5201_0002))
      else $error("downstream vc header wrong");
   vc_cap_one_a: assert property (p_rd(hit_cap1, 32'h0000_0800))
      else $error("vc capability one wrong");
   vc_cap_two_a: assert property (p_rd(hit_cap2, {VC1_PRESENT ? 8'h04 : 8'h00, 24'h0}))
      else $error("vc capability two wrong");
   down_budget_a: assert property (@(posedge CLK) disable iff (!rst_sync_r)
      (CE && state_r == PBVC_IDLE && PSEL && !PENABLE && !UPSTREAM
       && (PADDR == `PBVC_OFF_PB_DATA)) |=> (PSLVERR && PRDATA == 32'h0))
      else $error("budget register visible downstream");
   write_ignored_a: assert property (@(posedge CLK) disable iff (!rst_sync_r)
      (CE && state_r == PBVC_IDLE && PSEL && !PENABLE && PWRITE) |=> (PREADY && PRDATA == 32'h0))
      else $error("write answer did not finish");

   // Field by field views of each read answer
   wire take = CE && (state_r == PBVC_IDLE) && PSEL;
   wire take_rd = take && !PWRITE;

   property p_fld(logic hit, logic [31:0] mask, logic [31:0] val);
      @(posedge CLK) disable iff (!rst_sync_r)
      (take_rd && hit) |=> (PREADY && ((PRDATA & mask) == val));
   endproperty

   property p_err(logic hit);
      @(posedge CLK) disable iff (!rst_sync_r)
      (take && hit) |=> (PREADY && PSLVERR && PRDATA == 32'h0);
   endproperty

   // Budget data word
   base_idx0_a: assert property (p_fld(hit_pb_data && sel_max,
      32'h0000_00ff, 32'h0000_0004))
      else $error("base power wrong for index 0");

   base_idx1_a: assert property (p_fld(hit_pb_data && sel_sust,
      32'h0000_00ff, 32'h0000_0003))
      else $error("base power wrong for index 1");

   base_other_a: assert property (p_fld(hit_pb_data && !sel_known,
      32'h0000_00ff, 32'h0000_0000))
      else $error("base power not zero for unknown index");

   type_idx0_a: assert property (p_fld(hit_pb_data && sel_max,
      32'h0003_8000, 32'h0003_8000))
      else $error("condition type wrong for index 0");

   type_idx1_a: assert property (p_fld(hit_pb_data && sel_sust,
      32'h0003_8000, 32'h0001_8000))
      else $error("condition type wrong for index 1");

   type_other_a: assert property (p_fld(hit_pb_data && !sel_known,
      32'h0003_8000, 32'h0000_0000))
      else $error("condition type not zero for unknown index");

   scale_zero_a: assert property (p_fld(hit_pb_data,
      32'h0000_0300, 32'h0000_0000))
      else $error("data scale not zero");

   pm_state_a: assert property (p_fld(hit_pb_data,
      32'h0000_6000, 32'h0000_0000))
      else $error("power state not D0");

   substate_a: assert property (p_fld(hit_pb_data,
      32'h0000_1c00, 32'h0000_0000))
      else $error("power sub state not zero");

   rail_known_a: assert property (p_fld(hit_pb_data && sel_known,
      32'h001c_0000, 32'h0008_0000))
      else $error("power rail wrong");

   rail_other_a: assert property (p_fld(hit_pb_data && !sel_known,
      32'h001c_0000, 32'h0000_0000))
      else $error("power rail not zero for unknown index");

   data_rsvd_a: assert property (p_fld(hit_pb_data,
      32'hffe0_0000, 32'h0000_0000))
      else $error("budget data reserved bits set");

   // Budget capability word
   sys_alloc_a: assert property (p_fld(hit_pb_cap,
      32'h0000_0001, 32'h0000_0001))
      else $error("system allocated bit clear");

   cap_rsvd_a: assert property (p_fld(hit_pb_cap,
      32'hffff_fffe, 32'h0000_0000))
      else $error("budget capability reserved bits set");

   // Channel header word
   hdr_id_a: assert property (p_fld(hit_vc_hdr,
      32'h0000_ffff, 32'h0000_0002))
      else $error("channel capability id wrong");

   hdr_ver_a: assert property (p_fld(hit_vc_hdr,
      32'h000f_0000, 32'h0001_0000))
      else $error("channel capability version wrong");

   next_up_a: assert property (p_fld(hit_vc_hdr && UPSTREAM,
      32'hfff0_0000, 32'h2700_0000))
      else $error("upstream next offset wrong");

   next_down_a: assert property (p_fld(hit_vc_hdr && !UPSTREAM,
      32'hfff0_0000, 32'h5200_0000))
      else $error("downstream next offset wrong");

   // Header stays visible on every port kind
   down_vc_ok_a: assert property (@(posedge CLK) disable iff (!rst_sync_r)
      (take_rd && hit_vc_hdr && !UPSTREAM) |=> (PREADY && !PSLVERR))
      else $error("downstream header read flagged as error");

   // First channel capability word
   ext_cnt_a: assert property (p_fld(hit_cap1,
      32'h0000_0007, 32'h0000_0000))
      else $error("extended channel count not zero");

   lp_cnt_a: assert property (p_fld(hit_cap1,
      32'h0000_0070, 32'h0000_0000))
      else $error("low priority count not zero");

   ref_clk_a: assert property (p_fld(hit_cap1,
      32'h0000_0300, 32'h0000_0000))
      else $error("reference clock field not zero");

   entry_size_a: assert property (p_fld(hit_cap1,
      32'h0000_0c00, 32'h0000_0800))
      else $error("table entry size wrong");

   cap1_rsvd_a: assert property (p_fld(hit_cap1,
      32'hffff_f088, 32'h0000_0000))
      else $error("capability one reserved bits set");

   // Second channel capability word
   arb_cap_a: assert property (p_fld(hit_cap2,
      32'h0000_00ff, 32'h0000_0000))
      else $error("channel arbitration capability not zero");

   arb_off_vc1_a: assert property (p_fld(hit_cap2 && VC1_PRESENT,
      32'hff00_0000, 32'h0400_0000))
      else $error("table offset wrong with second channel");

   arb_off_none_a: assert property (p_fld(hit_cap2 && !VC1_PRESENT,
      32'hff00_0000, 32'h0000_0000))
      else $error("table offset wrong without second channel");

   cap2_rsvd_a: assert property (p_fld(hit_cap2,
      32'h00ff_ff00, 32'h0000_0000))
      else $error("capability two reserved bits set");

   // Answer shape and freezing
   ready_pulse_a: assert property (@(posedge CLK) disable iff (!rst_sync_r)
      (PREADY && CE) |=> !PREADY)
      else $error("ready held longer than one cycle");
   idle_zero_a: assert property (@(posedge CLK) disable iff (!rst_sync_r)
      !PREADY |-> (PRDATA == 32'h0 && !PSLVERR))
      else $error("answer lines not zero outside a reply");
   ready_cause_a: assert property (@(posedge CLK) disable iff (!rst_sync_r)
      $rose(PREADY) |-> $past(PSEL))
      else $error("ready without a request");
   freeze_a: assert property (@(posedge CLK) disable iff (!rst_sync_r)
      !CE |=> ($stable(PREADY) && $stable(PRDATA) && $stable(PSLVERR)))
      else $error("answer moved while clock enable low");
   down_cap_a: assert property (p_err(!UPSTREAM && PADDR == `PBVC_OFF_PB_CAP))
      else $error("budget capability visible downstream");
   unmapped_a: assert property (p_err(!hit_any))
      else $error("unmapped address answered without error");
   write_ok_a: assert property (@(posedge CLK) disable iff (!rst_sync_r)
      (take && PWRITE && hit_any) |=> (PREADY && !PSLVERR))
      else $error("write to a mapped word flagged as error");

   rd_budget_c: cover property (@(posedge CLK) PREADY && !PSLVERR && hit_pb_data);
   rd_vc_c: cover property (@(posedge CLK) PREADY && hit_cap2 && VC1_PRESENT);
   err_c: cover property (@(posedge CLK) PREADY && PSLVERR);
   rd_down_c: cover property (@(posedge CLK) PREADY && PSLVERR && !UPSTREAM);
   frozen_c: cover property (@(posedge CLK) !CE && PSEL);

endmodule

`default_nettype wire
